// ### inc/fbw_map.svh
// Offsets, command codes, field positions and timing constants of the flash write and protect control.
`ifndef FBW_MAP_SVH
`define FBW_MAP_SVH
`define FBW_CLK_NS 5
`define FBW_CYC_UP(ns) ((((ns) + `FBW_CLK_NS - 1) / `FBW_CLK_NS) < 1 ? 1 : (((ns) + `FBW_CLK_NS - 1) / `FBW_CLK_NS))
`define FBW_CYC_DN(ns) (((ns) / `FBW_CLK_NS) < 1 ? 1 : ((ns) / `FBW_CLK_NS))
`define FBW_T_ACC_NS 70
`define FBW_T_SLEEP_EXTRA_NS 60
`define FBW_T_SLOW_CLK_NS 200
`define FBW_T_RP_NS 30
`define FBW_T_READY_EA_NS 20000
`define FBW_T_READY_NS 500
`define FBW_FILT_SETTLE 3'h5
`define FBW_UL1_ADDR 11'h555
`define FBW_UL2_ADDR 11'h2AA
`define FBW_QRY_ADDR 11'h055
`define FBW_UL1_DATA 8'hAA
`define FBW_UL2_DATA 8'h55
`define FBW_CMD_PROG 8'hA0
`define FBW_CMD_ERASE 8'h80
`define FBW_CMD_CHIP 8'h10
`define FBW_CMD_SECT 8'h30
`define FBW_CMD_BYPASS 8'h20
`define FBW_CMD_ID 8'h90
`define FBW_CMD_QRY 8'h98
`define FBW_CMD_LOCK 8'h60
`define FBW_CMD_CFG 8'hC0
`define FBW_CMD_RST 8'hF0
`define FBW_CFG_SYNC_BIT 15
`define FBW_CFG_RST 16'h0000
`define FBW_LOCK_BIT 0
`define FBW_BOOST_LOW 2'h0
`define FBW_BOOST_HV_BIT 1
`define FBW_SECT_LAST_SMALL 8'h82
`define FBW_SECT_BIG_BASE 8'h03
`endif

// ### inc/fbw_pkg.sv
// Types shared by the flash write and protect control.
`default_nettype none
package fbw_pkg;
	typedef enum logic [3:0] {
		S_READ  = 4'h0,
		S_UL1   = 4'h1,
		S_UL2   = 4'h3,
		S_PROG  = 4'h2,
		S_ER1   = 4'h6,
		S_ER2   = 4'h7,
		S_ER3   = 4'h5,
		S_SEL   = 4'h4,
		S_LOCK  = 4'hC,
		S_CFG   = 4'hD
	} fbw_state_e;
	typedef enum logic [1:0] {
		OP_PROG       = 2'h0,
		OP_ERASE_SECT = 2'h1,
		OP_ERASE_CHIP = 2'h2
	} fbw_op_e;
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        avd_n;
		logic        bclk;
		logic        rst_n;
		logic        wp_n;
		logic [1:0]  boost;
		logic [21:0] addr;
		logic [15:0] data;
	} fbw_pins_s;
	typedef struct packed {
		fbw_op_e     kind;
		logic [7:0]  sector;
		logic [21:0] addr;
		logic [15:0] data;
	} fbw_op_s;
endpackage : fbw_pkg
`default_nettype wire

// ### hdl/fbw_ctrl.sv
// Bus write decode, sector protection, sleep, standby and reset control of a burst flash.
`timescale 1ns/1ps
`default_nettype none
`include "fbw_map.svh"
// Overview of operation
// - Program writes are accepted in both synchronous and asynchronous read mode.
// - Fast program mode needs two write cycles per word, otherwise four.
// - Erase covers one sector, several chosen sectors, or the whole device.
// - Boost input at high level enters fast program mode; removal leaves it.
// - Boost input low locks every sector against program and erase.
// - Identification sequence enters query mode, only in asynchronous read mode.
// - Chip select and reset both high give high impedance outputs.
// - Async mode sleeps after address stable for access time plus 60 ns.
// - Sync mode sleeps on late first clock edge or clock below 5 MHz.
// - Reset pulse aborts, tristates, clears configuration, ignores commands, returns to read.
// - Device is ready after reset within ready time, longer if busy.
// - Output enable high disables data outputs into high impedance.
// - Program and erase require unlock cycles, except program in fast program mode; lone writes are ignored.
// - Lock command disables or re-enables program and erase per sector.
// - Write protect low blocks boot pair sectors; high restores their lock state.
// - Write starts only with chip select and strobe low, output enable high.
// - Power-up resets to read and ignores strobe rising edge seen held low with chip select and reset low, output enable high.
// - Device starts in asynchronous read mode until configuration is written.
module fbw_ctrl import fbw_pkg::*; #(
	parameter bit          BOOT_TOP      = 1'b0,
	parameter int unsigned N_SECT        = 134,
	parameter int unsigned T_RP_NS       = `FBW_T_RP_NS,
	parameter int unsigned T_READY_EA_NS = `FBW_T_READY_EA_NS,
	parameter int unsigned T_READY_NS    = `FBW_T_READY_NS
) (
	input  wire logic        sys_clk_i,          // System clock, 200 MHz.
	input  wire logic        rstn_i,             // Asynchronous reset, active low.
	input  wire logic        ce_i,               // Clock enable, freezes all state except the reset synchronizer when low.
	input  wire logic        chip_sel_n_i,       // Chip select pin, active low.
	input  wire logic        out_en_n_i,         // Output enable pin, active low.
	input  wire logic        wr_strobe_n_i,      // Write strobe pin, active low.
	input  wire logic        address_valid_n_i,  // Address valid pin, active low.
	input  wire logic        bus_clk_i,          // Burst clock pin, sampled.
	input  wire logic        hw_reset_n_i,       // Hardware reset pin, active low.
	input  wire logic        wr_protect_n_i,     // Write protect pin, active low.
	input  wire logic [1:0]  program_boost_in_i, // Boost level: 0 low, 1 normal, 2/3 high.
	input  wire logic [21:0] addr_i,             // Address pins.
	input  wire logic [15:0] data_bus_i,         // Data bus input side.
	output logic      [15:0] data_bus_o,         // Data bus output side.
	output logic             data_bus_oe_o,      // Data bus drive enable.
	input  wire logic        busy_i,             // Embedded program or erase running.
	input  wire logic [15:0] array_data_i,       // Array read data.
	input  wire logic [15:0] query_data_i,       // Identification register data.
	input  wire logic        rd_valid_i,         // Read data valid strobe.
	output logic             rd_req_o,           // New read wanted.
	output fbw_op_s          op_o,               // Program or erase request.
	output logic             op_valid_o,         // Request pulse.
	output logic             op_reject_o,        // Protected target pulse.
	output logic             abort_o,            // Abort pulse on reset.
	output logic             query_mode_o,       // Query mode active.
	output logic             fast_prog_o,        // Fast program mode active.
	output logic             sync_mode_o,        // Synchronous read mode.
	output logic             sleep_o,            // Automatic sleep.
	output logic             standby_o,          // Standby.
	output logic             ready_o             // Accepting commands.
);
	localparam int ASLP_CYC = `FBW_CYC_UP(`FBW_T_ACC_NS + `FBW_T_SLEEP_EXTRA_NS);
	localparam int ACC_CYC  = `FBW_CYC_UP(`FBW_T_ACC_NS);
	localparam int SLOW_CYC = `FBW_CYC_DN(`FBW_T_SLOW_CLK_NS);
	localparam int RP_CYC   = `FBW_CYC_UP(T_RP_NS);
	localparam int RDE_CYC  = `FBW_CYC_UP(T_READY_EA_NS);
	localparam int RDI_CYC  = `FBW_CYC_UP(T_READY_NS);
	if (N_SECT != 134 || RDE_CYC > 65535 || RP_CYC > 65535) begin : g_chk
		$error("fbw_ctrl: sector count or reset timing out of range");
	end

	logic       rs1;
	logic       rst_n;
	fbw_pins_s  pin;
	fbw_pins_s  p1;
	fbw_pins_s  p2;
	fbw_pins_s  p3;
	fbw_pins_s  pf;
	fbw_pins_s  pq;
	fbw_pins_s  next_pf;
	fbw_state_e state;
	fbw_state_e next_state;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rs1   <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1   <= 1'b1;
			rst_n <= rs1;
		end
	end

	assign pin = '{chip_sel_n_i, out_en_n_i, wr_strobe_n_i, address_valid_n_i, bus_clk_i,
		hw_reset_n_i, wr_protect_n_i, program_boost_in_i, addr_i, data_bus_i};
	// A bit moves only once the second and third stages agree.
	assign next_pf = (p2 & p3) | (pf & (p2 | p3));

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			p1 <= '1;
			p2 <= '1;
			p3 <= '1;
			pf <= '1;
			pq <= '1;
		end else if (ce_i) begin
			p1 <= pin;
			p2 <= p1;
			p3 <= p2;
			pf <= next_pf;
			pq <= pf;
		end
	end

	logic [21:0]     addr_q;
	logic [15:0]     cfg_q;
	logic [N_SECT-1:0] lock_q;
	logic            byp_q;
	logic            query_q;
	logic            pu_inh;
	logic [2:0]      pu_cnt;
	logic            rst_taken;
	logic [15:0]     rp_cnt;
	logic [15:0]     rdy_cnt;
	logic            was_busy;
	logic [6:0]      slp_cnt;
	logic            first_pend;

	wire we_rise   = pf.we_n & ~pq.we_n;
	wire we_fall   = ~pf.we_n & pq.we_n;
	wire wr_ok     = ~pf.ce_n & pf.oe_n;
	wire wr_evt    = ce_i & we_rise & wr_ok & pf.rst_n & ~pu_inh & ready_o;
	wire [7:0] cmd = pf.data[7:0];
	wire is_ul1    = addr_q[10:0] == `FBW_UL1_ADDR && cmd == `FBW_UL1_DATA;
	wire is_ul2    = addr_q[10:0] == `FBW_UL2_ADDR && cmd == `FBW_UL2_DATA;
	wire is_qry    = addr_q[10:0] == `FBW_QRY_ADDR && cmd == `FBW_CMD_QRY;
	wire boost_low = pf.boost == `FBW_BOOST_LOW;
	wire boost_hv  = pf.boost[`FBW_BOOST_HV_BIT];
	wire sync_mode = cfg_q[`FBW_CFG_SYNC_BIT];
	wire byp       = byp_q | boost_hv;
	wire [7:0] sect = addr_q[21:15] == 7'h00 ? {6'h00, addr_q[14:13]} :
		addr_q[21:15] == 7'h7F ? `FBW_SECT_LAST_SMALL + {6'h00, addr_q[14:13]} :
		`FBW_SECT_BIG_BASE + {1'b0, addr_q[21:15]};
	wire [N_SECT-1:0] wp_mask = BOOT_TOP ? {2'b11, {(N_SECT-2){1'b0}}} : {{(N_SECT-2){1'b0}}, 2'b11};
	// Boost low, write protect and lock bits.
	wire [N_SECT-1:0] eff_lock = lock_q | (pf.wp_n ? '0 : wp_mask) | {N_SECT{boost_low}};
	wire prot_sect = eff_lock[sect];
	wire prot_chip = |eff_lock;

	logic    do_op;
	fbw_op_e op_kind;
	logic    lock_wr;
	logic    cfg_wr;
	logic    byp_set;
	logic    byp_clr;
	logic    qry_set;
	logic    qry_clr;

	always_comb begin
		next_state = state;
		do_op      = 1'b0;
		op_kind    = OP_PROG;
		lock_wr    = 1'b0;
		cfg_wr     = 1'b0;
		byp_set    = 1'b0;
		byp_clr    = 1'b0;
		qry_set    = 1'b0;
		qry_clr    = 1'b0;
		if (wr_evt) begin
			unique case (state)
				S_READ: begin
					if (byp && cmd == `FBW_CMD_PROG) next_state = S_PROG;
					else if (cmd == `FBW_CMD_RST) qry_clr = 1'b1;
					else if (byp_q && cmd == `FBW_CMD_ID) byp_clr = 1'b1;
					else if (is_ul1) next_state = S_UL1;
					else if (is_qry && !sync_mode) qry_set = 1'b1;
				end
				S_UL1: next_state = is_ul2 ? S_UL2 : S_READ;
				S_UL2: begin
					next_state = S_READ;
					unique case (cmd)
						`FBW_CMD_PROG:   next_state = S_PROG;
						`FBW_CMD_ERASE:  next_state = S_ER1;
						`FBW_CMD_LOCK:   next_state = S_LOCK;
						`FBW_CMD_CFG:    next_state = S_CFG;
						`FBW_CMD_BYPASS: byp_set = 1'b1;
						`FBW_CMD_ID:     qry_set = !sync_mode;
						default:         qry_clr = cmd == `FBW_CMD_RST;
					endcase
				end
				S_PROG: begin
					do_op      = 1'b1;
					next_state = S_READ;
				end
				S_ER1: next_state = is_ul1 ? S_ER2 : S_READ;
				S_ER2: next_state = is_ul2 ? S_ER3 : S_READ;
				S_ER3, S_SEL: begin
					next_state = S_READ;
					if (cmd == `FBW_CMD_SECT) begin
						do_op      = 1'b1;
						op_kind    = OP_ERASE_SECT;
						next_state = S_SEL;
					end else if (cmd == `FBW_CMD_CHIP && state == S_ER3) begin
						do_op   = 1'b1;
						op_kind = OP_ERASE_CHIP;
					end
				end
				S_LOCK: begin
					lock_wr    = 1'b1;
					next_state = S_READ;
				end
				S_CFG: begin
					cfg_wr     = 1'b1;
					next_state = S_READ;
				end
				default: next_state = S_READ;
			endcase
		end
	end

	wire op_prot = op_kind == OP_ERASE_CHIP ? prot_chip : prot_sect;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_READ;
			byp_q <= 1'b0;
			query_q <= 1'b0;
		end else if (ce_i) begin
			state   <= rst_taken ? S_READ : next_state;
			byp_q   <= ~rst_taken & (byp_set | (byp_q & ~byp_clr));
			query_q <= ~rst_taken & (qry_set | (query_q & ~qry_clr));
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q  <= `FBW_CFG_RST;
			lock_q <= '0;
		end else if (ce_i) begin
			if (rst_taken) cfg_q <= `FBW_CFG_RST;
			else if (cfg_wr) cfg_q <= pf.data;
			if (lock_wr) lock_q[sect] <= pf.data[`FBW_LOCK_BIT];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) addr_q <= '0;
		else if (ce_i && ((~pf.avd_n & wr_ok) || (we_fall & wr_ok))) addr_q <= pf.addr;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			op_o        <= '0;
			op_valid_o  <= 1'b0;
			op_reject_o <= 1'b0;
		end else if (ce_i) begin
			op_valid_o  <= do_op & ~op_prot;
			op_reject_o <= do_op & op_prot;
			if (do_op) op_o <= '{op_kind, sect, addr_q, pf.data};
		end
	end

	// The pin filter shows its reset value for a few cycles, so the pattern is judged once it has settled.
	// power-up inhibit
	wire first = pu_cnt != `FBW_FILT_SETTLE;
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pu_cnt <= '0;
			pu_inh <= 1'b0;
		end else if (ce_i) begin
			if (first) pu_cnt <= pu_cnt + 3'h1;
			if (first) pu_inh <= ~pf.we_n & ~pf.ce_n & ~pf.rst_n & pf.oe_n;
			else if (pf.we_n) pu_inh <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rp_cnt    <= '0;
			rst_taken <= 1'b0;
			abort_o   <= 1'b0;
			was_busy  <= 1'b0;
			rdy_cnt   <= '0;
		end else if (ce_i) begin
			rp_cnt    <= pf.rst_n ? '0 : (rp_cnt == 16'(RP_CYC) ? rp_cnt : rp_cnt + 16'h0001);
			rst_taken <= ~pf.rst_n && rp_cnt == 16'(RP_CYC - 1);
			abort_o   <= ~pf.rst_n && rp_cnt == 16'(RP_CYC - 1);
			if (rst_taken) was_busy <= busy_i;
			if (!pf.rst_n) rdy_cnt <= (rst_taken ? busy_i : was_busy) ? 16'(RDE_CYC) : 16'(RDI_CYC);
			else if (rdy_cnt != '0 && rp_cnt == '0) rdy_cnt <= rdy_cnt - 16'h0001;
		end
	end
	assign ready_o = pf.rst_n & (rdy_cnt == '0);

	wire addr_chg  = pf.addr != pq.addr;
	wire bclk_rise = pf.bclk & ~pq.bclk;
	wire burst_go  = ~pf.avd_n & pq.avd_n & ~pf.ce_n;
	wire slp_clr   = sync_mode ? (bclk_rise | burst_go) : addr_chg;
	wire [6:0] slp_thr = sync_mode ? (first_pend ? 7'(ACC_CYC) : 7'(SLOW_CYC + 1)) : 7'(ASLP_CYC);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			slp_cnt    <= '0;
			first_pend <= 1'b0;
		end else if (ce_i) begin
			slp_cnt    <= slp_clr ? '0 : (slp_cnt == 7'h7F ? slp_cnt : slp_cnt + 7'h01);
			first_pend <= burst_go | (first_pend & ~bclk_rise);
		end
	end
	assign sleep_o = slp_cnt >= slp_thr;

	// Output data stays latched through sleep; only a fresh read replaces it.
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_bus_o <= '0;
			rd_req_o   <= 1'b0;
		end else if (ce_i) begin
			rd_req_o <= ~pf.ce_n & pf.rst_n & (sync_mode ? burst_go : addr_chg);
			if (rd_valid_i) data_bus_o <= query_q ? query_data_i : array_data_i;
		end
	end

	assign data_bus_oe_o = ~pf.ce_n & ~pf.oe_n & pf.rst_n & ~rst_taken;
	assign standby_o     = pf.ce_n & pf.rst_n;
	assign fast_prog_o   = byp;
	assign query_mode_o  = query_q;
	assign sync_mode_o   = sync_mode;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	a_oe_hiz: assert property (pf.oe_n |-> !data_bus_oe_o) else $error("outputs driven with oe high");
	a_standby_hiz: assert property (pf.ce_n && pf.rst_n |-> !data_bus_oe_o && standby_o)
		else $error("outputs driven in standby");
	a_boost_lock: assert property (do_op && ce_i && boost_low |=> op_reject_o && !op_valid_o)
		else $error("op accepted with boost low");
	a_wp_boot: assert property (do_op && ce_i && op_kind == OP_PROG && !pf.wp_n && wp_mask[sect]
		|=> op_reject_o) else $error("boot sector written under write protect");
	a_fast_two: assert property (wr_evt && state == S_READ && byp && cmd == `FBW_CMD_PROG
		|=> state == S_PROG) else $error("fast program needed more cycles");
	a_unlock_need: assert property (op_valid_o |-> $past(state) inside {S_PROG, S_ER3, S_SEL})
		else $error("op without unlock sequence");
	a_reset_abort: assert property (rst_taken && ce_i |=> state == S_READ && !sync_mode && !query_q)
		else $error("reset did not return to read");
	a_write_gate: assert property (ce_i && we_rise && !wr_ok |=> !op_valid_o && !op_reject_o)
		else $error("write taken while inhibited");
	a_query_async: assert property (query_q |-> !sync_mode || $past(query_q))
		else $error("query entered in sync mode");
	a_async_sleep: assert property (!sync_mode && !slp_clr && slp_cnt == 7'(ASLP_CYC - 1) && ce_i
		|=> sleep_o) else $error("no sleep after stable address");
	a_pu_ignore: assert property (pu_inh && ce_i && we_rise |=> !op_valid_o && state == $past(state))
		else $error("power-up write accepted");
	c_program: cover property (op_valid_o && op_o.kind == OP_PROG);
	c_sect_multi: cover property (op_valid_o && op_o.kind == OP_ERASE_SECT ##[1:40] op_valid_o);
	c_reset_busy: cover property (rst_taken && busy_i);
	c_sleep: cover property (sleep_o && sync_mode);
endmodule : fbw_ctrl
`default_nettype wire

// ### tb/fbw_host.sv
// Host memory controller model that drives the flash bus pins.
`timescale 1ns/1ps
`default_nettype none
module fbw_host (
	input  wire logic        sys_clk_i, // System clock.
	output logic             cs_n_o,    // Chip select, active low.
	output logic             oe_n_o,    // Output enable, active low.
	output logic             we_n_o,    // Write strobe, active low.
	output logic             av_n_o,    // Address valid, active low.
	output logic             bclk_o,    // Burst clock, held low.
	output logic [21:0]      addr_o,    // Address pins.
	output logic [15:0]      data_o     // Data driven by the host.
);
	initial begin
		{cs_n_o, oe_n_o, we_n_o, av_n_o, bclk_o} = 5'h1E;
		addr_o = 22'h0;
		data_o = 16'h0;
	end
	// write cycle framing.
	// The hold count lets a scenario answer promptly or slowly; two cycles is the filter floor.
	task automatic wr(input logic [21:0] a, input logic [15:0] d, input logic oe, input int hold);
		@(negedge sys_clk_i);
		{cs_n_o, oe_n_o, we_n_o, av_n_o, bclk_o} = {1'b0, oe, 3'h0};
		addr_o = a;
		data_o = d;
		repeat (hold) @(negedge sys_clk_i);
		we_n_o = 1'b1;
		repeat (hold) @(negedge sys_clk_i);
		idle();
	endtask : wr
	// A released bus shows the inverse of the last value, so stale data never passes for a match.
	task automatic idle();
		{cs_n_o, oe_n_o, we_n_o, av_n_o} = 4'hF;
		data_o = ~data_o;
	endtask : idle
	// Holds the pattern that a powering host may leave on the pins, with the strobe still low.
	task automatic pu_hold(input logic [21:0] a, input logic [15:0] d);
		@(negedge sys_clk_i);
		{cs_n_o, oe_n_o, we_n_o, av_n_o, bclk_o} = 5'h0A;
		addr_o = a;
		data_o = d;
	endtask : pu_hold
	task automatic pu_rise();
		@(negedge sys_clk_i);
		we_n_o = 1'b1;
		repeat (5) @(negedge sys_clk_i);
		idle();
	endtask : pu_rise
	task automatic rd(input logic [21:0] a);
		@(negedge sys_clk_i);
		{cs_n_o, oe_n_o, we_n_o, av_n_o} = 4'h3;
		addr_o = a;
		data_o = ~data_o;
	endtask : rd
endmodule : fbw_host
`default_nettype wire

// ### tb/fbw_ctrl_tb.sv
// Self-checking testbench of the flash write and protect control.
`timescale 1ns/1ps
`default_nettype none
`include "fbw_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module fbw_ctrl_tb import fbw_pkg::*; ;
	logic        sys_clk_i, rstn_i, hw_reset_n_i, wr_protect_n_i, busy_i, rd_valid_i, ce_i;
	logic [1:0]  program_boost_in_i;
	logic        cs_n, oe_n, we_n, av_n, bclk;
	logic [21:0] addr;
	logic [15:0] host_d, dut_d, arr_d, qry_d;
	logic        bus_oe, rd_req, op_v, op_r, abrt, qry, fast, sync, slp, stby, rdy;
	fbw_op_s     op;
	int          fails, num_checks, n_ok, n_rej, n_abort, ok0, rej0, n;
	wire  [15:0] bus_w = bus_oe ? dut_d : host_d;

	fbw_host u_fbw_host (.sys_clk_i(sys_clk_i), .cs_n_o(cs_n), .oe_n_o(oe_n), .we_n_o(we_n),
		.av_n_o(av_n), .bclk_o(bclk), .addr_o(addr), .data_o(host_d));
	fbw_ctrl #(.T_READY_EA_NS(50), .T_READY_NS(20)) u_fbw_ctrl (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n),
		.wr_strobe_n_i(we_n), .address_valid_n_i(av_n), .bus_clk_i(bclk), .hw_reset_n_i(hw_reset_n_i),
		.wr_protect_n_i(wr_protect_n_i), .program_boost_in_i(program_boost_in_i), .addr_i(addr),
		.data_bus_i(bus_w), .data_bus_o(dut_d), .data_bus_oe_o(bus_oe), .busy_i(busy_i),
		.array_data_i(arr_d), .query_data_i(qry_d), .rd_valid_i(rd_valid_i), .rd_req_o(rd_req),
		.op_o(op), .op_valid_o(op_v), .op_reject_o(op_r), .abort_o(abrt), .query_mode_o(qry),
		.fast_prog_o(fast), .sync_mode_o(sync), .sleep_o(slp), .standby_o(stby), .ready_o(rdy));

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// Pulses are counted on the falling edge, where they have settled.
	always @(negedge sys_clk_i) begin
		if (op_v === 1'b1) n_ok++;
		if (op_r === 1'b1) n_rej++;
		if (abrt === 1'b1) n_abort++;
	end
	// The core answers each read request half a cycle later.
	always @(negedge sys_clk_i) rd_valid_i <= rd_req;

	task automatic stop_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task automatic wt(input int c);
		repeat (c) @(negedge sys_clk_i);
	endtask : wt
	task automatic w(input logic [21:0] a, input logic [15:0] d);
		u_fbw_host.wr(a, d, 1'b1, 5);
	endtask : w
	task automatic ul();
		w(22'(`FBW_UL1_ADDR), 16'(`FBW_UL1_DATA));
		w(22'(`FBW_UL2_ADDR), 16'(`FBW_UL2_DATA));
	endtask : ul
	task automatic cmd(input logic [7:0] c);
		ul();
		w(22'(`FBW_UL1_ADDR), {8'h00, c});
	endtask : cmd
	task automatic res(input string nm, input int dok, input int drej);
		wt(4);
		`CHK({nm, " accepted"}, dok, n_ok - ok0)
		`CHK({nm, " refused"}, drej, n_rej - rej0)
		ok0 = n_ok;
		rej0 = n_rej;
	endtask : res
	task automatic wait_rdy();
		n = 0;
		while (rdy !== 1'b1 && n < 200) begin
			wt(1);
			n++;
		end
		if (n >= 200) begin
			fails++;
			stop_test();
		end
	endtask : wait_rdy

	task automatic t_idle();
		`CHK("ready", 1'b1, rdy)
		`CHK("sync", 1'b0, sync)
		`CHK("standby", 1'b1, stby)
		`CHK("drive", 1'b0, bus_oe)
		$display("idle test done");
	endtask : t_idle
	task automatic t_prog();
		cmd(`FBW_CMD_PROG);
		w(22'h100123, 16'hBEEF);
		res("prog", 1, 0);
		`CHK("kind", OP_PROG, op.kind)
		`CHK("addr", 22'h100123, op.addr)
		`CHK("data", 16'hBEEF, op.data)
		w(22'(`FBW_UL1_ADDR), 16'(`FBW_CMD_PROG));
		w(22'h100124, 16'h0101);
		res("lone", 0, 0);
		u_fbw_host.wr(22'(`FBW_UL1_ADDR), 16'(`FBW_UL1_DATA), 1'b0, 5);
		u_fbw_host.wr(22'(`FBW_UL2_ADDR), 16'(`FBW_UL2_DATA), 1'b0, 9);
		u_fbw_host.wr(22'(`FBW_UL1_ADDR), 16'(`FBW_CMD_PROG), 1'b0, 5);
		u_fbw_host.wr(22'h100125, 16'h0202, 1'b0, 5);
		res("oe low", 0, 0);
		$display("program test done");
	endtask : t_prog
	task automatic t_boost();
		// Sectors are all unlocked here before the boost level is raised.
		program_boost_in_i = 2'h2;
		wt(8);
		`CHK("fast", 1'b1, fast)
		w(22'h0, 16'(`FBW_CMD_PROG));
		w(22'h100200, 16'h1111);
		res("fast prog", 1, 0);
		program_boost_in_i = 2'h1;
		wt(8);
		`CHK("normal", 1'b0, fast)
		w(22'h0, 16'(`FBW_CMD_PROG));
		w(22'h100201, 16'h1111);
		res("two cycles", 0, 0);
		cmd(`FBW_CMD_BYPASS);
		`CHK("bypass", 1'b1, fast)
		w(22'h0, 16'(`FBW_CMD_PROG));
		w(22'h100210, 16'h1111);
		res("bypass prog", 1, 0);
		w(22'h0, 16'(`FBW_CMD_ID));
		`CHK("bypass off", 1'b0, fast)
		program_boost_in_i = 2'h0;
		wt(8);
		cmd(`FBW_CMD_PROG);
		w(22'h100202, 16'h1111);
		res("boost low", 0, 1);
		program_boost_in_i = 2'h1;
		wt(8);
		$display("boost test done");
	endtask : t_boost
	task automatic t_prot();
		cmd(`FBW_CMD_LOCK);
		w(22'h100000, 16'h0001);
		cmd(`FBW_CMD_PROG);
		w(22'h100010, 16'h2222);
		res("locked", 0, 1);
		cmd(`FBW_CMD_LOCK);
		w(22'h100000, 16'h0000);
		cmd(`FBW_CMD_PROG);
		w(22'h100010, 16'h2222);
		res("unlocked", 1, 0);
		wr_protect_n_i = 1'b0;
		wt(8);
		cmd(`FBW_CMD_PROG);
		w(22'h000100, 16'h3333);
		res("wp sect0", 0, 1);
		cmd(`FBW_CMD_PROG);
		w(22'h004100, 16'h3333);
		res("wp sect2", 1, 0);
		wr_protect_n_i = 1'b1;
		wt(8);
		cmd(`FBW_CMD_PROG);
		w(22'h000100, 16'h3333);
		res("wp high", 1, 0);
		$display("protect test done");
	endtask : t_prot
	task automatic t_erase();
		cmd(`FBW_CMD_ERASE);
		ul();
		w(22'h100000, 16'(`FBW_CMD_SECT));
		w(22'h180000, 16'(`FBW_CMD_SECT));
		res("sect erase", 2, 0);
		`CHK("sect kind", OP_ERASE_SECT, op.kind)
		`CHK("sect num", 8'h33, op.sector)
		w(22'h0, 16'(`FBW_CMD_RST));
		cmd(`FBW_CMD_ERASE);
		cmd(`FBW_CMD_CHIP);
		res("chip erase", 1, 0);
		`CHK("chip kind", OP_ERASE_CHIP, op.kind)
		$display("erase test done");
	endtask : t_erase
	task automatic t_query();
		cmd(`FBW_CMD_ID);
		wt(8);
		`CHK("query", 1'b1, qry)
		u_fbw_host.rd(22'h000001);
		wt(20);
		`CHK("drive", 1'b1, bus_oe)
		`CHK("query data", 16'h0051, bus_w)
		@(negedge sys_clk_i);
		u_fbw_host.idle();
		wt(6);
		`CHK("oe high", 1'b0, bus_oe)
		w(22'h0, 16'(`FBW_CMD_RST));
		wt(8);
		`CHK("query off", 1'b0, qry)
		w(22'h000055, 16'(`FBW_CMD_QRY));
		`CHK("query cmd", 1'b1, qry)
		w(22'h0, 16'(`FBW_CMD_RST));
		`CHK("query end", 1'b0, qry)
		$display("query test done");
	endtask : t_query
	task automatic t_sleep();
		u_fbw_host.rd(22'h000040);
		wt(8);
		`CHK("awake", 1'b0, slp)
		wt(30);
		`CHK("asleep", 1'b1, slp)
		arr_d = 16'h5678;
		wt(2);
		`CHK("latched", 16'h1234, bus_w)
		u_fbw_host.rd(22'h000041);
		wt(8);
		`CHK("woken", 1'b0, slp)
		`CHK("new data", 16'h5678, bus_w)
		@(negedge sys_clk_i);
		u_fbw_host.idle();
		$display("sleep test done");
	endtask : t_sleep
	task automatic t_rst();
		cmd(`FBW_CMD_CFG);
		w(22'h0, 16'h8000);
		wt(8);
		`CHK("sync on", 1'b1, sync)
		cmd(`FBW_CMD_PROG);
		w(22'h100300, 16'h4444);
		res("sync prog", 1, 0);
		cmd(`FBW_CMD_ID);
		wt(8);
		`CHK("no query", 1'b0, qry)
		u_fbw_host.rd(22'h0);
		wt(50);
		`CHK("sync sleep", 1'b1, slp)
		n_abort = 0;
		busy_i = 1'b1;
		hw_reset_n_i = 1'b0;
		wt(14);
		`CHK("abort", 1, n_abort)
		`CHK("tristate", 1'b0, bus_oe)
		`CHK("not ready", 1'b0, rdy)
		u_fbw_host.idle();
		cmd(`FBW_CMD_PROG);
		w(22'h100301, 16'h4444);
		res("in reset", 0, 0);
		hw_reset_n_i = 1'b1;
		busy_i = 1'b0;
		wait_rdy();
		`CHK("busy ready", 1'b1, n >= 10)
		`CHK("cfg cleared", 1'b0, sync)
		cmd(`FBW_CMD_PROG);
		w(22'h100301, 16'h4444);
		res("restart", 1, 0);
		hw_reset_n_i = 1'b0;
		wt(14);
		hw_reset_n_i = 1'b1;
		wait_rdy();
		`CHK("idle ready", 1'b1, n < 10)
		$display("reset test done");
	endtask : t_rst
	task automatic t_ce();
		ul();
		ce_i = 1'b0;
		w(22'(`FBW_UL1_ADDR), 16'(`FBW_CMD_PROG));
		ce_i = 1'b1;
		w(22'h100400, 16'h5555);
		res("frozen", 0, 0);
		$display("clock enable test done");
	endtask : t_ce
	task automatic t_pwr();
		u_fbw_host.pu_hold(22'(`FBW_UL1_ADDR), 16'(`FBW_UL1_DATA));
		hw_reset_n_i = 1'b0;
		wt(8);
		rstn_i = 1'b0;
		wt(6);
		rstn_i = 1'b1;
		wt(12);
		hw_reset_n_i = 1'b1;
		wait_rdy();
		u_fbw_host.pu_rise();
		w(22'(`FBW_UL2_ADDR), 16'(`FBW_UL2_DATA));
		w(22'(`FBW_UL1_ADDR), 16'(`FBW_CMD_PROG));
		w(22'h100500, 16'h6666);
		res("power-up", 0, 0);
		cmd(`FBW_CMD_PROG);
		w(22'h100500, 16'h6666);
		res("after power-up", 1, 0);
		$display("power-up test done");
	endtask : t_pwr

	initial begin
		#400000;
		fails++;
		stop_test();
	end
	initial begin
		// Reset is held from time zero through power-up.
		{rstn_i, hw_reset_n_i, wr_protect_n_i, busy_i, ce_i} = 5'h0D;
		program_boost_in_i = 2'h1;
		arr_d = 16'h1234;
		qry_d = 16'h0051;
		wt(6);
		rstn_i = 1'b1;
		wt(12);
		t_idle();
		t_prog();
		t_boost();
		t_prot();
		t_ce();
		t_erase();
		t_query();
		t_sleep();
		t_pwr();
		t_rst();
		stop_test();
	end
endmodule : fbw_ctrl_tb
`default_nettype wire
